// >>> hdl/fcr_pkg.sv
/*
  Shared constants and types of the flash controller register block.
  Assumes a 32-bit register port and a flash engine on the same clock.
*/
package fcr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] FCR_BASE      = 32'hffff_fa00;
  localparam logic [7:0]  FCR_OFS_MODE  = 8'h00;
  localparam logic [7:0]  FCR_OFS_CMD   = 8'h04;
  localparam logic [7:0]  FCR_OFS_STAT  = 8'h08;
  localparam logic [7:0]  FCR_OFS_RES   = 8'h0c;
  localparam logic [7:0]  FCR_OFS_IPEND = 8'h20;
  localparam logic [7:0]  FCR_OFS_IMASK = 8'h24;
  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  FCR_KEY          = 8'h5a;
  localparam int          FCR_MODE_IE_BIT  = 0;
  localparam int          FCR_MODE_WS_LSB  = 8;
  localparam int          FCR_WS_W         = 4;
  localparam int          FCR_ST_RDY       = 0;
  localparam int          FCR_ST_CMDE      = 1;
  localparam int          FCR_ST_LOCKE     = 2;
  localparam int          FCR_EV_W         = 3;
  localparam logic [31:0] FCR_MODE_RST     = 32'h0000_0000;
  localparam logic [31:0] FCR_STAT_RST     = 32'h0000_0001;
  localparam logic [31:0] FCR_RES_RST      = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    CMD_PROG      = 8'h01,
    CMD_ERASE_ALL = 8'h02,
    CMD_SET_LOCK  = 8'h03,
    CMD_CLR_LOCK  = 8'h04,
    CMD_GET_LOCK  = 8'h05,
    CMD_SET_NV    = 8'h06,
    CMD_CLR_NV    = 8'h07,
    CMD_GET_NV    = 8'h08
  } fcr_code_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_EVAL = 3'b011,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b110
  } fcr_state_t;
  typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_LOCK = 2'h1, SRC_NV = 2'h2} fcr_src_t;
  typedef struct packed {
    logic [7:0]  write_guard_key;
    logic [15:0] command_argument;
    logic [7:0]  command_code;
  } fcr_cmd_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fcr_bus_t;
  typedef struct packed {
    logic        start;
    logic        erase_all;
    logic [15:0] page;
  } fcr_fl_req_t;
endpackage

// >>> hdl/fcr_lock_mem.sv
/*
  Lock bit store: one write port, one read port, registered read data.
  Assumes write and read on the same clock; a same-address read
  returns the old word.
*/
`timescale 1ns/10ps
module fcr_lock_mem #(
  parameter int W  = 32,
  parameter int D  = 2,
  parameter int AW = 1
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_r
);
  logic [W-1:0] mem_r [D];

  // ---------------------------------------------------------------
  // Storage; no reset so it maps onto plain RAM
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_r <= mem_r[raddr];
  end
endmodule

// >>> hdl/fcr_ctrl.sv
/*
  Flash controller register block: mode, keyed command, status and
  result registers, a lock and nonvolatile bit sequencer, and the
  access wait-state timer. Assumes the flash engine and the access
  requester run on core_clk; lock bits live in fcr_lock_mem.
*/
// Design decision made here: the strobed register port.
// Function
// - Four registers at base, consecutive word offsets; code adds interrupt pending and mask registers at 8'h20 and 8'h24
// - Ready interrupt only when its enable is one
// - Each access takes wait states plus one
// - Command launches only with matching top-byte key
// - Wrong key discards write, starts nothing
// - Argument is page, nv index, or ignored
// - Ready reads zero busy, one when idle
// - Ready and enable set raise interrupt
// - Hardware clears ready on becoming busy
// - Bad code or key sets command error
// - Locked program or erase sets lock error
// - Status read or command write clears errors
// - Results wider than 32 bits read sequentially
// - Get results lowest first, then zeros
// - Erase touching any lock refused entirely
// - Program starts and ready clears at write; ready clears then, but an in-range page starts only after its lock check
`timescale 1ns/10ps
module fcr_ctrl
  import fcr_pkg::*;
#(
  parameter int LOCK_WORDS   = 2,
  parameter int REGION_SHIFT = 4,
  parameter int NV_BITS      = 4
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire fcr_bus_t     bus,
  output logic [31:0]       rd_data,
  output fcr_fl_req_t       fl_req,
  input  wire logic         fl_done,
  input  wire logic         acc_req,
  output logic              acc_ack,
  output logic [NV_BITS-1:0] nv_bits,
  output logic              irq
);
  localparam int          LAW       = (LOCK_WORDS > 1) ? $clog2(LOCK_WORDS) : 1;
  localparam int          RIW       = LAW + 1;
  localparam logic [15:0] LOCK_BITS = 16'(LOCK_WORDS * 32);

  // ---------------------------------------------------------------
  // Argument decoding, shared by launch and evaluation
  // ---------------------------------------------------------------
  function automatic logic [15:0] region_of(input logic [15:0] arg);
    region_of = arg >> REGION_SHIFT;
  endfunction
  function automatic logic [LAW-1:0] word_of(input logic [15:0] arg);
    logic [15:0] r;
    r       = region_of(arg);
    word_of = r[5 +: LAW];
  endfunction
  function automatic logic [4:0] bit_of(input logic [15:0] arg);
    logic [15:0] r;
    r      = region_of(arg);
    bit_of = r[4:0];
  endfunction
  function automatic logic code_valid(input logic [7:0] c);
    code_valid = (c >= CMD_PROG) && (c <= CMD_GET_NV);
  endfunction

  fcr_state_t           state_r, state_nxt;
  fcr_cmd_t             cmd_r, cmd_nxt;
  fcr_src_t             src_r, src_nxt;
  logic [LAW-1:0]       idx_r, idx_nxt;
  logic [RIW-1:0]       res_idx_r, res_idx_nxt;
  logic [NV_BITS-1:0]   nv_r, nv_nxt;
  logic                 rdy_ie_r;
  logic [FCR_WS_W-1:0]  ws_limit_r, ws_cnt_r;
  logic                 rdy_r, cmde_r, locke_r, ws_busy_r;
  logic [FCR_EV_W-1:0]  pend_r, mask_r;
  logic                 lock_hit, fl_go, mem_we;
  logic [31:0]          mem_q;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  wire        hit      = bus.addr[31:8] == FCR_BASE[31:8];
  wire  [7:0] ofs      = bus.addr[7:0];
  wire        wr_mode  = bus.wr && hit && ofs == FCR_OFS_MODE;
  wire        wr_cmd   = bus.wr && hit && ofs == FCR_OFS_CMD;
  wire        wr_ipend = bus.wr && hit && ofs == FCR_OFS_IPEND;
  wire        wr_imask = bus.wr && hit && ofs == FCR_OFS_IMASK;
  wire        rd_stat  = bus.rd && hit && ofs == FCR_OFS_STAT;
  wire        rd_res   = bus.rd && hit && ofs == FCR_OFS_RES;
  wire fcr_cmd_t cmd_in = fcr_cmd_t'(bus.wdata);

  // Key, code and idle state must all agree before anything starts
  wire key_ok = cmd_in.write_guard_key == FCR_KEY;
  wire launch = wr_cmd && key_ok && code_valid(cmd_in.command_code) && rdy_r;
  wire bad_cmd = wr_cmd && !launch;

  // ---------------------------------------------------------------
  // Sequencer helpers
  // ---------------------------------------------------------------
  wire              in_rng   = region_of(cmd_in.command_argument) < LOCK_BITS;
  wire              nv_ok    = cmd_in.command_argument < 16'(NV_BITS);
  wire [NV_BITS-1:0] nv_sel  = nv_ok ? NV_BITS'(1) << cmd_in.command_argument : '0;
  wire [31:0]       bit_mask = 32'h1 << bit_of(cmd_r.command_argument);
  wire [31:0]       mem_wd   = (cmd_r.command_code == CMD_SET_LOCK) ? (mem_q | bit_mask)
                                                                   : (mem_q & ~bit_mask);
  wire              last_wd  = idx_r == LAW'(LOCK_WORDS - 1);
  // Result reads use the memory port only in IDLE and DONE, so ready is held
  // back one cycle (DONE) until the first result word is in place
  wire              res_port = state_r == ST_IDLE || state_r == ST_DONE;
  wire [LAW-1:0]    mem_ra   = res_port ? res_idx_nxt[LAW-1:0] : idx_r;

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    idx_nxt   = idx_r;
    nv_nxt    = nv_r;
    lock_hit  = 1'b0;
    fl_go     = 1'b0;
    mem_we    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          cmd_nxt = cmd_in;
          idx_nxt = word_of(cmd_in.command_argument);
          case (cmd_in.command_code)
            CMD_PROG: begin
              state_nxt = in_rng ? ST_READ : ST_EXEC;
              fl_go     = !in_rng;
            end
            CMD_ERASE_ALL: begin
              idx_nxt   = '0;
              state_nxt = ST_READ;
            end
            CMD_SET_LOCK, CMD_CLR_LOCK: state_nxt = in_rng ? ST_READ : ST_DONE;
            CMD_SET_NV: begin
              nv_nxt    = nv_r | nv_sel;
              state_nxt = ST_DONE;
            end
            CMD_CLR_NV: begin
              nv_nxt    = nv_r & ~nv_sel;
              state_nxt = ST_DONE;
            end
            default: state_nxt = ST_DONE;
          endcase
        end
      end
      ST_READ: state_nxt = ST_EVAL;
      ST_EVAL: begin
        case (cmd_r.command_code)
          CMD_PROG: begin
            if (mem_q[bit_of(cmd_r.command_argument)]) begin
              lock_hit  = 1'b1;
              state_nxt = ST_DONE;
            end else begin
              fl_go     = 1'b1;
              state_nxt = ST_EXEC;
            end
          end
          CMD_ERASE_ALL: begin
            if (|mem_q) begin
              lock_hit  = 1'b1;
              state_nxt = ST_DONE;
            end else if (last_wd) begin
              fl_go     = 1'b1;
              state_nxt = ST_EXEC;
            end else begin
              idx_nxt   = idx_r + LAW'(1);
              state_nxt = ST_READ;
            end
          end
          default: begin
            mem_we    = 1'b1;
            state_nxt = ST_DONE;
          end
        endcase
      end
      ST_EXEC: state_nxt = fl_done ? ST_DONE : ST_EXEC;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cmd_r   <= '0;
      idx_r   <= '0;
      nv_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      idx_r   <= idx_nxt;
      nv_r    <= nv_nxt;
    end
  end

  fcr_lock_mem #(
    .W  (32),
    .D  (LOCK_WORDS),
    .AW (LAW)
  ) u_lock_mem (
    .core_clk (core_clk),
    .we       (mem_we),
    .waddr    (idx_r),
    .wdata    (mem_wd),
    .raddr    (mem_ra),
    .rdata_r  (mem_q)
  );

  // ---------------------------------------------------------------
  // Flash engine request, one-cycle start pulse
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fl_req <= '0;
    end else begin
      fl_req.start <= fl_go;
      if (fl_go) begin
        fl_req.erase_all <= cmd_nxt.command_code == CMD_ERASE_ALL;
        fl_req.page      <= cmd_nxt.command_argument;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status flags; a set in the clearing cycle wins
  // ---------------------------------------------------------------
  wire err_clr = rd_stat || wr_cmd;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdy_r   <= FCR_STAT_RST[FCR_ST_RDY];
      cmde_r  <= FCR_STAT_RST[FCR_ST_CMDE];
      locke_r <= FCR_STAT_RST[FCR_ST_LOCKE];
    end else begin
      if (launch) begin
        rdy_r <= 1'b0;
      end else if (state_r == ST_DONE) begin
        rdy_r <= 1'b1;
      end
      cmde_r  <= bad_cmd || (cmde_r && !err_clr);
      locke_r <= lock_hit || (locke_r && !err_clr);
    end
  end

  // ---------------------------------------------------------------
  // Result pointer; words past the meaningful ones read zero
  // ---------------------------------------------------------------
  wire res_lock = src_r == SRC_LOCK && res_idx_r < RIW'(LOCK_WORDS);
  wire res_nv   = src_r == SRC_NV && res_idx_r == '0;
  wire [31:0] result_word = res_lock ? mem_q :
                            res_nv ? 32'(nv_r) : FCR_RES_RST;
  wire res_sat  = res_idx_r == RIW'(LOCK_WORDS);
  assign res_idx_nxt = launch ? '0 : (rd_res && !res_sat) ? res_idx_r + RIW'(1) : res_idx_r;
  always_comb begin
    src_nxt = src_r;
    if (launch) begin
      case (cmd_in.command_code)
        CMD_GET_LOCK: src_nxt = SRC_LOCK;
        CMD_GET_NV:   src_nxt = SRC_NV;
        default:      src_nxt = SRC_NONE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_r     <= SRC_NONE;
      res_idx_r <= '0;
    end else begin
      src_r     <= src_nxt;
      res_idx_r <= res_idx_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Mode, interrupt pending and mask registers
  // ---------------------------------------------------------------
  wire [FCR_EV_W-1:0] ev = {lock_hit, bad_cmd, state_r == ST_DONE};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdy_ie_r   <= FCR_MODE_RST[FCR_MODE_IE_BIT];
      ws_limit_r <= FCR_MODE_RST[FCR_MODE_WS_LSB +: FCR_WS_W];
      mask_r     <= '0;
    end else begin
      if (wr_mode) begin
        rdy_ie_r   <= bus.wdata[FCR_MODE_IE_BIT];
        ws_limit_r <= bus.wdata[FCR_MODE_WS_LSB +: FCR_WS_W];
      end
      if (wr_imask) begin
        mask_r <= bus.wdata[FCR_EV_W-1:0];
      end
    end
  end
  generate
    for (genvar i = 0; i < FCR_EV_W; i++) begin : g_pend
      // Write one to clear; an event in the same cycle keeps the bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          pend_r[i] <= 1'b0;
        end else begin
          pend_r[i] <= ev[i] || (pend_r[i] && !(wr_ipend && bus.wdata[i]));
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (rdy_ie_r && rdy_r) || |(pend_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // ---------------------------------------------------------------
  wire [31:0] mode_rd = {20'h0, ws_limit_r, 7'h0, rdy_ie_r};
  wire [31:0] stat_rd = {29'h0, locke_r, cmde_r, rdy_r};
  wire [31:0] rd_mux  = (ofs == FCR_OFS_MODE)  ? mode_rd :
                        (ofs == FCR_OFS_STAT)  ? stat_rd :
                        (ofs == FCR_OFS_RES)   ? result_word :
                        (ofs == FCR_OFS_IPEND) ? 32'(pend_r) :
                        (ofs == FCR_OFS_IMASK) ? 32'(mask_r) : 32'h0;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= (bus.rd && hit) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Access timer: ack in cycle wait states plus one after request
  // ---------------------------------------------------------------
  wire ws_start = acc_req && !ws_busy_r && !acc_ack;
  wire ws_end   = (ws_start && ws_limit_r == '0) || (ws_busy_r && ws_cnt_r == ws_limit_r);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ws_busy_r <= 1'b0;
      ws_cnt_r  <= '0;
      acc_ack   <= 1'b0;
    end else begin
      acc_ack   <= ws_end;
      ws_busy_r <= (ws_start || ws_busy_r) && !ws_end;
      ws_cnt_r  <= ws_start ? FCR_WS_W'(1) : ws_cnt_r + FCR_WS_W'(1);
    end
  end
  assign nv_bits = nv_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [FCR_WS_W:0] ws_seen_r;
  always_ff @(posedge core_clk) begin
    ws_seen_r <= ws_start ? (FCR_WS_W+1)'(1) : ws_seen_r + (FCR_WS_W+1)'(1);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_key_discard: assert property (wr_cmd && !key_ok && rdy_r |=> state_r == ST_IDLE && cmde_r && rdy_r)
    else $error("wrong key write was not discarded");
  a_ready_drop: assert property (launch |=> !rdy_r ##0 stat_rd[0] == 1'b0)
    else $error("ready did not clear on launch");
  a_irq_quiet: assert property (!rdy_ie_r && (pend_r & mask_r) == '0 |=> !irq)
    else $error("interrupt raised with ready disabled");
  a_irq_ready: assert property (rdy_ie_r && rdy_r |=> irq)
    else $error("ready interrupt missing");
  a_wait_count: assert property ($rose(acc_ack) |-> ws_seen_r == {1'b0, ws_limit_r} + (FCR_WS_W+1)'(1))
    else $error("access ack not at wait states plus one");
  a_err_clear: assert property (rd_stat && !bad_cmd && !lock_hit |=> !cmde_r && !locke_r)
    else $error("error flags not cleared by status read");
  a_erase_refuse: assert property (state_r == ST_EVAL && cmd_r.command_code == CMD_ERASE_ALL && |mem_q
    |=> locke_r && !fl_req.start ##1 rdy_r)
    else $error("locked erase not refused");
  a_prog_start: assert property (state_r == ST_EVAL && cmd_r.command_code == CMD_PROG && !lock_hit
    |=> fl_req.start && fl_req.page == cmd_r.command_argument ##1 !fl_req.start)
    else $error("program start pulse wrong");
  a_res_zero: assert property (rd_res && !res_lock && !res_nv |=> rd_data == 32'h0)
    else $error("extra result read not zero");

  c_erase_run:  cover property (fl_req.start && fl_req.erase_all ##[1:20] rdy_r);
  c_lock_read:  cover property (src_r == SRC_LOCK && rd_res ##2 rd_res);
  c_wait_ack:   cover property (ws_limit_r == 4'h2 && $rose(acc_ack));
  c_lock_error: cover property ($rose(locke_r) ##[1:10] irq);
endmodule

// >>> bench/fcr_flash_model.sv
/*
  Behavioural flash engine: answers each start pulse with a done pulse.
  Assumes fl_req comes from fcr_ctrl on the same core_clk.
*/
`timescale 1ns/10ps
module fcr_flash_model
  import fcr_pkg::*;
#(
  parameter int DLY = 5
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire fcr_fl_req_t fl_req,
  output logic             fl_done
);
  int cnt_r;
  // Countdown per operation; never answers in the start cycle, like a slow array
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r   <= 0;
      fl_done <= 1'b0;
    end else begin
      fl_done <= (cnt_r == 1);
      if (fl_req.start) begin
        cnt_r <= DLY;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule

// >>> bench/fcr_ctrl_tb.sv
/*
  Self-checking bench of the flash controller register block.
  Assumes the flash engine model answers every start pulse.
*/
`timescale 1ns/10ps
module fcr_ctrl_tb;
  import fcr_pkg::*;
  logic        core_clk;
  logic        sys_rst;
  logic        acc_req;
  fcr_bus_t    bus;
  logic [31:0] rd_data;
  fcr_fl_req_t fl_req;
  fcr_fl_req_t last_req;
  logic        fl_done;
  logic        acc_ack;
  logic [3:0]  nv_bits;
  logic        irq;
  int          n_errors;
  int          cmp_count;
  int          n_start;

  fcr_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data), .fl_req(fl_req),
    .fl_done(fl_done), .acc_req(acc_req), .acc_ack(acc_ack), .nv_bits(nv_bits), .irq(irq));
  fcr_flash_model flash (.core_clk(core_clk), .sys_rst(sys_rst), .fl_req(fl_req), .fl_done(fl_done));

  // ---------------------------------------------------------------
  // Clock, start monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Count flash start pulses so refused commands can be told apart
  always @(posedge core_clk) begin
    if (fl_req.start === 1'b1) begin
      n_start++;
      last_req = fl_req;
    end
  end
  // Whole run is a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= FCR_BASE | {24'h0, a};
    bus.wdata <= d;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    bus.rd   <= 1'b1;
    bus.addr <= FCR_BASE | {24'h0, a};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, e, $sformatf("read %h", a));
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] arg);
    wr(FCR_OFS_CMD, {FCR_KEY, arg, c});
  endtask
  // Poll the completion pending bit, so status flags stay unread
  task automatic wait_done();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      bus.rd   <= 1'b1;
      bus.addr <= FCR_BASE | {24'h0, FCR_OFS_IPEND};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1;
      if (rd_data[0] === 1'b1) break;
    end
    chk({31'h0, rd_data[0]}, 32'h1, "completion");
    wr(FCR_OFS_IPEND, 32'h1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rdc(FCR_OFS_MODE, 32'h0);
    rdc(FCR_OFS_STAT, 32'h1);
    rdc(FCR_OFS_RES, 32'h0);
    rdc(8'h10, 32'h0);
    wr(FCR_OFS_MODE, 32'hffff_f2fe);
    rdc(FCR_OFS_MODE, 32'h0000_0200);
    $display("test regs done");
  endtask
  task automatic t_badcmd();
    int n;
    n = n_start;
    wr(FCR_OFS_CMD, {8'ha5, 16'h0, 8'h01});
    rdc(FCR_OFS_STAT, 32'h3);
    rdc(FCR_OFS_STAT, 32'h1);
    cmd(8'h09, 16'h0);
    rdc(FCR_OFS_STAT, 32'h3);
    cmd(8'h09, 16'h0);
    cmd(CMD_GET_NV, 16'h0);
    wait_done();
    rdc(FCR_OFS_STAT, 32'h1);
    chk(n_start, n, "starts");
    wr(FCR_OFS_IPEND, 32'h7);
    $display("test bad command done");
  endtask
  task automatic t_prog();
    int n;
    n = n_start;
    cmd(CMD_PROG, 16'h0003);
    rdc(FCR_OFS_STAT, 32'h0);
    wait_done();
    chk(n_start, n + 1, "starts");
    chk({16'h0, last_req.page}, 32'h3, "page");
    chk({31'h0, last_req.erase_all}, 32'h0, "kind");
    rdc(FCR_OFS_STAT, 32'h1);
    $display("test program done");
  endtask
  task automatic t_lock();
    int n;
    cmd(CMD_SET_LOCK, 16'h0012);
    wait_done();
    cmd(CMD_GET_LOCK, 16'hffff);
    wait_done();
    rdc(FCR_OFS_RES, 32'h2);
    rdc(FCR_OFS_RES, 32'h0);
    rdc(FCR_OFS_RES, 32'h0);
    n = n_start;
    cmd(CMD_PROG, 16'h0015);
    wait_done();
    rdc(FCR_OFS_STAT, 32'h5);
    cmd(CMD_ERASE_ALL, 16'h0);
    wait_done();
    rdc(FCR_OFS_STAT, 32'h5);
    chk(n_start, n, "starts");
    cmd(CMD_CLR_LOCK, 16'h0010);
    wait_done();
    cmd(CMD_ERASE_ALL, 16'h0);
    wait_done();
    chk(n_start, n + 1, "starts");
    chk({31'h0, last_req.erase_all}, 32'h1, "kind");
    $display("test lock done");
  endtask
  task automatic t_nv();
    cmd(CMD_SET_NV, 16'h0002);
    wait_done();
    chk({28'h0, nv_bits}, 32'h4, "nv bits");
    cmd(CMD_GET_NV, 16'h0);
    wait_done();
    rdc(FCR_OFS_RES, 32'h4);
    rdc(FCR_OFS_RES, 32'h0);
    cmd(CMD_CLR_NV, 16'h0002);
    wait_done();
    chk({28'h0, nv_bits}, 32'h0, "nv clear");
    cmd(CMD_SET_NV, 16'h0009);
    wait_done();
    chk({28'h0, nv_bits}, 32'h0, "nv out of range");
    $display("test nv done");
  endtask
  task automatic t_irq();
    wr(FCR_OFS_MODE, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(FCR_OFS_MODE, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq off");
    wr(FCR_OFS_IMASK, 32'h2);
    wr(FCR_OFS_CMD, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq masked on");
    wr(FCR_OFS_IPEND, 32'h2);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(FCR_OFS_IMASK, 32'h0);
    rdc(FCR_OFS_STAT, 32'h3);
    $display("test irq done");
  endtask
  // Access timing for a table of wait-state values
  task automatic t_acc();
    int k;
    int ws_tab [3] = '{0, 2, 15};
    foreach (ws_tab[w]) begin
      wr(FCR_OFS_MODE, ws_tab[w] << 8);
      @(posedge core_clk);
      acc_req <= 1'b1;
      for (k = 1; k < 30; k++) begin
        @(posedge core_clk);
        #1;
        if (acc_ack === 1'b1) break;
      end
      chk(k, ws_tab[w] + 1, "access cycles");
      @(posedge core_clk);
      acc_req <= 1'b0;
      #1;
      chk({31'h0, acc_ack}, 32'h0, "ack length");
    end
    $display("test access done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    sys_rst   = 1'b1;
    bus       = '0;
    acc_req   = 1'b0;
    n_errors  = 0;
    cmp_count = 0;
    n_start   = 0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_badcmd();
    t_prog();
    t_lock();
    t_nv();
    t_irq();
    t_acc();
    end_of_test();
  end
endmodule
